// *** verilog/pgw_gpio.sv ***
// Two general-purpose pins with debounce, edge interrupts and alternate functions.
// Assumes pins arrive asynchronously and the interrupt line has an external pull-up.
`timescale 1ns/1ps

// Notes on behaviour
// R1: Direction bit zero makes the pin an output driving the programmed level.
// R2: Drive style one drives both levels; zero only pulls low (open-drain).
// R3: Pin level status tracks the sensed pin even while it is an output.
// R4: Direction bit one stops driving the pin; it becomes an input.
// R5: Filter enabled: input change accepted only after a 30 ms interval.
// R6: Filter disabled: level changes go to the interrupt logic without filter delay.
// R7: Rising and falling edges on each pin set separate interrupt bits.
// R8: Each edge bit has a mask; zero lets it assert, one blocks it.
// R9: Interrupt output low while any unmasked bit is set, else released.
// R10: All mask bits come out of reset masked; masked bits never act.
// R11: Interrupt output is active low open-drain, only pulling low.
// R12: Each pin has a readable alternate select; one picks alternate function.
// R13: Alternate pin zero is active-high input for channel 0 voltage scaling.
// R14: Alternate pin one outputs the channel 2 power-sequencer slot signal.
// R15: Edge interrupt bits stay latched until software clears them.
// R16: Debounce restarts on every transition; level updates after full stable interval.
module pgw_gpio
    import pgw_pkg::*;
#(
    parameter int FILT_CYCLES = FILT_CYC
) (
    input  wire logic                 mclk,
    input  wire logic                 srst,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic [DATA_W-1:0]    pwdata,
    output logic      [DATA_W-1:0]    prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [PIN_CNT-1:0]   pinIn,
    output logic      [PIN_CNT-1:0]   pinOut,
    output logic      [PIN_CNT-1:0]   pinOe,
    input  wire logic                 seqSlotCh2,
    output logic                      dvsCtlCh0,
    output logic                      interruptRequestOutN,
    output logic                      interruptRequestOe
);

    localparam logic [FILT_CNT_W-1:0] FILT_LAST = FILT_CNT_W'(FILT_CYCLES - 1);

    pgw_pin_cfg_t             pinCfg_r [PIN_CNT];
    logic [IRQ_W-1:0]         irqStat_r;
    logic [IRQ_W-1:0]         irqMask_r;
    logic [IRQ_W-1:0]         irqSet;
    logic [IRQ_W-1:0]         irqClr;
    logic [PIN_CNT-1:0]       syncA_r;
    logic [PIN_CNT-1:0]       syncB_r;
    logic [PIN_CNT-1:0]       syncPrev_r;
    logic [PIN_CNT-1:0]       filtLvl_r;
    logic [PIN_CNT-1:0]       filtPrev_r;
    logic [PIN_CNT-1:0]       lvlNow;
    logic [FILT_CNT_W-1:0]    filtCnt_r [PIN_CNT];
    pgw_pin_drv_t             pinDrv [PIN_CNT];
    logic                     setupRd;
    logic                     accessWr;
    logic                     addrHit;
    logic                     irqActive;
    logic [DATA_W-1:0]        rdMux;

    // Bus decode
    assign setupRd  = psel & ~penable & ~pwrite;
    assign accessWr = psel & penable & pwrite;

    always_comb begin
        case (paddr)
            ADR_PIN0_CFG, ADR_PIN1_CFG, ADR_IRQ_STAT, ADR_IRQ_CLR, ADR_IRQ_MASK: addrHit = 1'b1;
            default: addrHit = 1'b0;
        endcase
    end

    assign pready  = psel & penable;
    assign pslverr = psel & penable & ~addrHit;

    always_comb begin
        rdMux = '0;
        case (paddr)
            ADR_PIN0_CFG: begin
                rdMux[CFG_DIR_BIT] = pinCfg_r[0].dirIn;
                rdMux[CFG_DRV_BIT] = pinCfg_r[0].driveStyle;
                rdMux[CFG_OUT_BIT] = pinCfg_r[0].outLevel;
                rdMux[CFG_FLT_BIT] = pinCfg_r[0].filterOn;
                rdMux[CFG_ALT_BIT] = pinCfg_r[0].altSel;     // [R12]
                rdMux[CFG_LVL_BIT] = lvlNow[0];              // [R3]
            end
            ADR_PIN1_CFG: begin
                rdMux[CFG_DIR_BIT] = pinCfg_r[1].dirIn;
                rdMux[CFG_DRV_BIT] = pinCfg_r[1].driveStyle;
                rdMux[CFG_OUT_BIT] = pinCfg_r[1].outLevel;
                rdMux[CFG_FLT_BIT] = pinCfg_r[1].filterOn;
                rdMux[CFG_ALT_BIT] = pinCfg_r[1].altSel;     // [R12]
                rdMux[CFG_LVL_BIT] = lvlNow[1];              // [R3]
            end
            ADR_IRQ_STAT: rdMux[IRQ_W-1:0] = irqStat_r;
            ADR_IRQ_MASK: rdMux[IRQ_W-1:0] = irqMask_r;
            default:      rdMux = '0;
        endcase
    end

    // Read data captured in the setup cycle, stable through the access phase
    always_ff @(posedge mclk) begin
        if (srst) begin
            prdata <= '0;
        end else if (setupRd) begin
            prdata <= rdMux;
        end
    end

    // Pin configuration registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            pinCfg_r[0] <= PIN_CFG_RST;
            pinCfg_r[1] <= PIN_CFG_RST;
        end else if (accessWr) begin
            if (paddr == ADR_PIN0_CFG) begin
                pinCfg_r[0] <= '{altSel: pwdata[CFG_ALT_BIT], filterOn: pwdata[CFG_FLT_BIT],
                                 outLevel: pwdata[CFG_OUT_BIT], driveStyle: pwdata[CFG_DRV_BIT],
                                 dirIn: pwdata[CFG_DIR_BIT]};
            end
            if (paddr == ADR_PIN1_CFG) begin
                pinCfg_r[1] <= '{altSel: pwdata[CFG_ALT_BIT], filterOn: pwdata[CFG_FLT_BIT],
                                 outLevel: pwdata[CFG_OUT_BIT], driveStyle: pwdata[CFG_DRV_BIT],
                                 dirIn: pwdata[CFG_DIR_BIT]};
            end
        end
    end

    // Mask register, all masked after reset
    always_ff @(posedge mclk) begin
        if (srst) begin
            irqMask_r <= IRQ_MASK_RST;                       // [R10]
        end else if (accessWr && paddr == ADR_IRQ_MASK) begin
            irqMask_r <= pwdata[IRQ_W-1:0];
        end
    end

    assign irqClr = (accessWr && paddr == ADR_IRQ_CLR) ? pwdata[IRQ_W-1:0] : '0;

    // Per-pin input path
    genvar gi;
    generate
        for (gi = 0; gi < PIN_CNT; gi++) begin : gPin
            // Reset to the pulled-up idle level so no false edge follows reset
            always_ff @(posedge mclk) begin
                if (srst) begin
                    syncA_r[gi] <= 1'b1;
                    syncB_r[gi] <= 1'b1;
                end else begin
                    syncA_r[gi] <= pinIn[gi];
                    syncB_r[gi] <= syncA_r[gi];
                end
            end

            // Debounce counter restarts whenever the raw level moves
            always_ff @(posedge mclk) begin
                if (srst) begin
                    syncPrev_r[gi] <= 1'b1;
                    filtLvl_r[gi]  <= 1'b1;
                    filtCnt_r[gi]  <= '0;
                end else begin
                    syncPrev_r[gi] <= syncB_r[gi];
                    if (!pinCfg_r[gi].filterOn) begin
                        filtLvl_r[gi] <= syncB_r[gi];        // [R6]
                        filtCnt_r[gi] <= '0;
                    end else if (syncB_r[gi] != syncPrev_r[gi]) begin
                        filtCnt_r[gi] <= '0;                 // [R16]
                    end else if (syncB_r[gi] != filtLvl_r[gi]) begin
                        if (filtCnt_r[gi] == FILT_LAST) begin
                            filtLvl_r[gi] <= syncB_r[gi];    // [R5] [R16]
                            filtCnt_r[gi] <= '0;
                        end else begin
                            filtCnt_r[gi] <= filtCnt_r[gi] + 1'b1;
                        end
                    end else begin
                        filtCnt_r[gi] <= '0;
                    end
                end
            end

            // Unfiltered mode bypasses the filter flop to save a cycle
            assign lvlNow[gi] = pinCfg_r[gi].filterOn ? filtLvl_r[gi] : syncB_r[gi]; // [R3] [R6]

            always_ff @(posedge mclk) begin
                if (srst) begin
                    filtPrev_r[gi] <= 1'b1;
                end else begin
                    filtPrev_r[gi] <= lvlNow[gi];
                end
            end

            assign irqSet[IRQ_RISE_LSB+gi] = lvlNow[gi] & ~filtPrev_r[gi];  // [R7]
            assign irqSet[IRQ_FALL_LSB+gi] = ~lvlNow[gi] & filtPrev_r[gi];  // [R7]
        end
    endgenerate

    // Sticky status; a new edge wins over a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            irqStat_r <= '0;
        end else begin
            irqStat_r <= (irqStat_r & ~irqClr) | irqSet;     // [R15]
        end
    end

    assign irqActive = |(irqStat_r & ~irqMask_r);            // [R8] [R9] [R10]

    // Open-drain interrupt: only ever drives low
    assign interruptRequestOutN = 1'b0;                      // [R11]
    assign interruptRequestOe   = irqActive;                 // [R9] [R11]

    // Pin drivers
    always_comb begin
        for (int i = 0; i < PIN_CNT; i++) begin
            if (pinCfg_r[i].dirIn) begin
                pinDrv[i] = '{pinOut: 1'b0, pinOe: 1'b0};                       // [R4]
            end else if (pinCfg_r[i].driveStyle) begin
                pinDrv[i] = '{pinOut: pinCfg_r[i].outLevel, pinOe: 1'b1};       // [R1] [R2]
            end else begin
                pinDrv[i] = '{pinOut: 1'b0, pinOe: ~pinCfg_r[i].outLevel};      // [R1] [R2]
            end
        end
        if (pinCfg_r[0].altSel) begin
            pinDrv[0] = '{pinOut: 1'b0, pinOe: 1'b0};                           // [R13]
        end
        if (pinCfg_r[1].altSel) begin
            pinDrv[1] = '{pinOut: seqSlotCh2, pinOe: 1'b1};                     // [R14]
        end
    end

    generate
        for (gi = 0; gi < PIN_CNT; gi++) begin : gDrv
            assign pinOut[gi] = pinDrv[gi].pinOut;
            assign pinOe[gi]  = pinDrv[gi].pinOe;
        end
    endgenerate

    assign dvsCtlCh0 = pinCfg_r[0].altSel & lvlNow[0];                          // [R13]

endmodule

// *** verilog/pgw_pkg.sv ***
// Package for the two-pin GPIO block with interrupt support.
// Assumes a 10 MHz mclk and an APB master of 32-bit data.
package pgw_pkg;

    localparam int          PIN_CNT      = 2;
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;

    // Register byte addresses
    localparam logic [7:0]  ADR_PIN0_CFG = 8'h00;
    localparam logic [7:0]  ADR_PIN1_CFG = 8'h04;
    localparam logic [7:0]  ADR_IRQ_STAT = 8'h08;
    localparam logic [7:0]  ADR_IRQ_CLR  = 8'h0C;
    localparam logic [7:0]  ADR_IRQ_MASK = 8'h10;

    // Pin configuration field positions
    localparam int          CFG_DIR_BIT  = 0;
    localparam int          CFG_DRV_BIT  = 1;
    localparam int          CFG_OUT_BIT  = 2;
    localparam int          CFG_FLT_BIT  = 3;
    localparam int          CFG_ALT_BIT  = 4;
    localparam int          CFG_LVL_BIT  = 5;

    // Interrupt status layout: rise bits low, fall bits high
    localparam int          IRQ_RISE_LSB = 0;
    localparam int          IRQ_FALL_LSB = 2;
    localparam int          IRQ_W        = 4;
    localparam logic [3:0]  IRQ_MASK_RST = 4'hF;

    // Debounce interval
    localparam int          MCLK_HZ      = 10_000_000;
    localparam int          FILT_MS      = 30;
    localparam int          FILT_CYC     = (MCLK_HZ / 1000) * FILT_MS;
    localparam int          FILT_CNT_W   = 19;

    typedef struct packed {
        logic altSel;
        logic filterOn;
        logic outLevel;
        logic driveStyle;
        logic dirIn;
    } pgw_pin_cfg_t;

    localparam pgw_pin_cfg_t PIN_CFG_RST = '{altSel: 1'b0, filterOn: 1'b0, outLevel: 1'b0,
                                             driveStyle: 1'b0, dirIn: 1'b1};

    typedef struct packed {
        logic pinOut;
        logic pinOe;
    } pgw_pin_drv_t;

endpackage

// *** test/pgw_pin_model.sv ***
// Far side of the GPIO block: pin wiring with pull-ups and the host interrupt line.
// Assumes the bench never drives a pin that the block drives.
`timescale 1ns/1ps
module pgw_pin_model (
    input  wire logic [1:0] pinOut,
    input  wire logic [1:0] pinOe,
    input  wire logic [1:0] extEn,
    input  wire logic [1:0] extLvl,
    input  wire logic       irqOutN,
    input  wire logic       irqOe,
    output logic      [1:0] pinLine,
    output logic            irqLine
);
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pinLine[i] = pinOe[i] ? pinOut[i] : (extEn[i] ? extLvl[i] : 1'b1);
        end
        irqLine = irqOe ? irqOutN : 1'b1;
    end
endmodule

// *** test/pgw_gpio_chk.sv ***
// Concurrent checks on the ports of the GPIO block.
// Assumes one mclk domain with synchronous srst.
`timescale 1ns/1ps
module pgw_gpio_chk
    import pgw_pkg::*;
#(
    parameter int FILT_CYCLES = 8
) (
    input  wire logic                 mclk,
    input  wire logic                 srst,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic [DATA_W-1:0]    pwdata,
    input  wire logic [DATA_W-1:0]    prdata,
    input  wire logic                 pready,
    input  wire logic                 pslverr,
    input  wire logic [PIN_CNT-1:0]   pinIn,
    input  wire logic [PIN_CNT-1:0]   pinOut,
    input  wire logic [PIN_CNT-1:0]   pinOe,
    input  wire logic                 seqSlotCh2,
    input  wire logic                 dvsCtlCh0,
    input  wire logic                 interruptRequestOutN,
    input  wire logic                 interruptRequestOe
);
    logic wrAcc;
    logic wr0;
    assign wrAcc = psel && penable && pwrite;
    assign wr0   = wrAcc && paddr == ADR_PIN0_CFG;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    a_irq_low_only: assert property (interruptRequestOutN == 1'b0)
        else $error("interrupt pin driven high");
    a_reset_quiet: assert property ($fell(srst) |-> !interruptRequestOe && pinOe == 2'b00)
        else $error("outputs active after reset");
    a_irq_sticky: assert property (interruptRequestOe && !wrAcc |=> interruptRequestOe)
        else $error("interrupt dropped without a write");
    a_mask_all: assert property (wrAcc && paddr == ADR_IRQ_MASK && pwdata[3:0] == 4'hF |=> !interruptRequestOe)
        else $error("masked bits still assert interrupt");
    a_push_pull: assert property (wr0 && (pwdata[4:0] & 5'h13) == 5'h02
        |=> pinOe[0] && pinOut[0] == $past(pwdata[CFG_OUT_BIT]))
        else $error("push-pull drive wrong");
    a_open_drain: assert property (wr0 && (pwdata[4:0] & 5'h13) == 5'h00
        |=> !pinOut[0] && pinOe[0] == !$past(pwdata[CFG_OUT_BIT]))
        else $error("open-drain drive wrong");
    a_input_float: assert property (wr0 && pwdata[CFG_DIR_BIT] |=> !pinOe[0])
        else $error("input pin still driven");
    a_alt_slot: assert property (wrAcc && paddr == ADR_PIN1_CFG && pwdata[CFG_ALT_BIT]
        |=> pinOe[1] && pinOut[1] == seqSlotCh2)
        else $error("alternate output does not follow slot");
    a_dvs_gated: assert property (wr0 && !pwdata[CFG_ALT_BIT] |=> !dvsCtlCh0)
        else $error("scaling control active without alternate");
    c_irq: cover property ($rose(interruptRequestOe));
    c_dvs: cover property (dvsCtlCh0);
    c_err: cover property (psel && penable && pslverr);
endmodule
bind pgw_gpio pgw_gpio_chk #(.FILT_CYCLES(FILT_CYCLES)) u_chk (.*);

// *** test/tb_top.sv ***
// Self-checking bench for the GPIO block over APB.
// Assumes the pin model supplies pull-ups; short debounce of 8 cycles.
`timescale 1ns/1ps
module tb_top;
    import pgw_pkg::*;
    logic        mclk, srst, psel, penable, pwrite, pready, pslverr, err;
    logic        seqSlotCh2, dvsCtlCh0, irqN, irqOe, irqLine;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  pinOut, pinOe, pinLine, extEn, extLvl;
    int          failCount, comparisons, cycles;

    pgw_gpio #(.FILT_CYCLES(8)) i_dut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pinIn(pinLine), .pinOut(pinOut), .pinOe(pinOe), .seqSlotCh2(seqSlotCh2),
        .dvsCtlCh0(dvsCtlCh0), .interruptRequestOutN(irqN), .interruptRequestOe(irqOe));
    pgw_pin_model i_ext (.pinOut(pinOut), .pinOe(pinOe), .extEn(extEn), .extLvl(extLvl),
        .irqOutN(irqN), .irqOe(irqOe), .pinLine(pinLine), .irqLine(irqLine));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failCount++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic drv(input logic [1:0] en, input logic [1:0] lvl);
        @(posedge mclk);
        extEn <= en;
        extLvl <= lvl;
    endtask
    task automatic finishTest();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, failCount);
        if (failCount == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            failCount++;
            finishTest();
        end
    end

    initial begin
        {srst, psel, penable, pwrite, paddr, pwdata, seqSlotCh2} = {1'b1, 44'h0};
        {extEn, extLvl, failCount, comparisons, cycles} = '0;
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        wt(4);
        chk(irqOe, 1'b0);
        rdchk(ADR_IRQ_MASK, 32'hF);
        rdchk(ADR_IRQ_STAT, 32'h0);
        rdchk(ADR_PIN0_CFG, 32'h21);
        rdchk(8'h20, 32'h0);
        chk(err, 1'b1);
        $display("Test reset done");
        apb(1'b1, ADR_PIN0_CFG, 32'h2);
        wt(4);
        rdchk(ADR_PIN0_CFG, 32'h02);
        apb(1'b1, ADR_PIN0_CFG, 32'h4);
        wt(1);
        chk({pinOe[0], pinLine[0]}, 2'b01);
        apb(1'b1, ADR_PIN0_CFG, 32'h6);
        wt(1);
        chk({pinOe[0], pinOut[0]}, 2'b11);
        apb(1'b1, ADR_PIN0_CFG, 32'h1);
        wt(1);
        chk(pinOe[0], 1'b0);
        $display("Test outputs done");
        apb(1'b1, ADR_IRQ_CLR, 32'hF);
        apb(1'b1, ADR_IRQ_MASK, 32'hE);
        drv(2'b01, 2'b00);
        wt(6);
        chk(irqOe, 1'b0);
        rdchk(ADR_IRQ_STAT, 32'h4);
        drv(2'b00, 2'b00);
        wt(4);
        chk({irqOe, irqLine}, 2'b10);
        wt(10);
        rdchk(ADR_IRQ_STAT, 32'h5);
        apb(1'b1, ADR_IRQ_CLR, 32'h1);
        wt(1);
        chk(irqOe, 1'b0);
        apb(1'b1, ADR_IRQ_MASK, 32'h0);
        wt(1);
        chk(irqOe, 1'b1);
        apb(1'b1, ADR_IRQ_MASK, 32'hF);
        wt(1);
        chk(irqOe, 1'b0);
        $display("Test interrupts done");
        apb(1'b1, ADR_PIN0_CFG, 32'h9);
        wt(12);
        apb(1'b1, ADR_IRQ_CLR, 32'hF);
        drv(2'b01, 2'b00);
        wt(4);
        drv(2'b00, 2'b00);
        wt(12);
        rdchk(ADR_IRQ_STAT, 32'h0);
        drv(2'b01, 2'b00);
        wt(6);
        rdchk(ADR_IRQ_STAT, 32'h0);
        wt(12);
        rdchk(ADR_IRQ_STAT, 32'h4);
        drv(2'b00, 2'b00);
        $display("Test filter done");
        apb(1'b1, ADR_PIN0_CFG, 32'h11);
        wt(4);
        chk(dvsCtlCh0, 1'b1);
        rdchk(ADR_PIN0_CFG, 32'h31);
        drv(2'b01, 2'b00);
        wt(4);
        chk(dvsCtlCh0, 1'b0);
        @(posedge mclk);
        seqSlotCh2 <= 1'b1;
        apb(1'b1, ADR_PIN1_CFG, 32'h11);
        wt(1);
        chk({pinOe[1], pinLine[1]}, 2'b11);
        @(posedge mclk);
        seqSlotCh2 <= 1'b0;
        wt(4);
        chk(pinLine[1], 1'b0);
        rdchk(ADR_PIN1_CFG, 32'h11);
        $display("Test alternate done");
        finishTest();
    end
endmodule
